// ===== wdu_pkg.sv
package wdu_pkg;

  // ----------------------------------------------------------------------
  // Register indices and field positions
  // ----------------------------------------------------------------------
  localparam logic [1:0]  ADDR_CLOCK_CONTROL = 2'h0;
  localparam logic [1:0]  ADDR_CONTROL       = 2'h1;
  localparam logic [1:0]  ADDR_PROTECTION    = 2'h2;

  localparam int          POS_RUN_IN_DEBUG   = 8;
  localparam int          POS_DIV_LO         = 4;
  localparam int          POS_SRC_LO         = 0;
  localparam int          POS_IRQ_OR_RESET   = 9;
  localparam int          POS_OVF_STATUS     = 8;
  localparam int          POS_RESTART        = 4;
  localparam int          POS_RUN_LO         = 0;

  // ----------------------------------------------------------------------
  // Values
  // ----------------------------------------------------------------------
  localparam logic [15:0] PROTECTION_KEY     = 16'h0096;
  localparam logic [3:0]  RUN_STOP_CODE      = 4'ha;
  localparam logic [3:0]  RUN_RUNNING_READ   = 4'h0;
  // Any code but the stop code runs; this is the one the host writes.
  localparam logic [3:0]  RUN_START_CODE     = 4'h5;
  localparam int          COUNTER_WIDTH      = 10;
  localparam logic [9:0]  COUNTER_MAX        = 10'h3ff;

  // Division ratios, as log2 of the divisor, per source and divider code.
  localparam logic [4:0]  LOG2_DIV_OSC_BASE  = 5'h0d;
  localparam logic [4:0]  LOG2_DIV_LOW_XTAL  = 5'h07;
  localparam logic [4:0]  LOG2_DIV_EXT       = 5'h00;
  localparam logic [1:0]  SRC_INTERNAL_OSC   = 2'h0;
  localparam logic [1:0]  SRC_LOW_XTAL       = 2'h1;
  localparam logic [1:0]  SRC_HIGH_OSC       = 2'h2;
  localparam logic [1:0]  SRC_EXT_CLOCK      = 2'h3;
  localparam int          PRESCALE_WIDTH     = 16;

endpackage

// ===== wdu_if.sv
`timescale 1ns/1ps
interface wdu_if;
  // Register access from the processor side.
  logic        wr_en;
  logic [1:0]  addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  // Source clock ticks, one-cycle enables from the clock generator.
  logic [3:0]  src_tick;
  logic        debug_mode;
  // Overflow consequences.
  logic        nmi_req;
  logic        sys_reset_req;

  modport device
  (
    input  wr_en, addr, wdata, src_tick, debug_mode,
    output rdata, nmi_req, sys_reset_req
  );
  modport host
  (
    output wr_en, addr, wdata, src_tick, debug_mode,
    input  rdata, nmi_req, sys_reset_req
  );
endinterface

// ===== wdu_watchdog_unit.sv
`timescale 1ns/1ps

module wdu_watchdog_unit
(
  // Clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_rstn,
  // Link to the processor side
  wdu_if.device     bus
);

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic                                 unlocked;
  logic                                 run_in_debug;
  logic [1:0]                           clock_divider_select;
  logic [1:0]                           clock_source_select;
  logic                                 interrupt_or_reset_select;
  logic                                 overflow_interrupt_status;
  logic                                 running;
  logic [wdu_pkg::COUNTER_WIDTH-1:0]    count;
  logic [wdu_pkg::PRESCALE_WIDTH-1:0]   prescale;
  logic                                 nmi_req;
  logic                                 sys_reset_req;
  logic [15:0]                          rdata;

  // ----------------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------------
  // A write strobe aimed at one register index.
  function automatic logic write_hit
  (
    input logic       wr_en,
    input logic [1:0] addr,
    input logic [1:0] index
  );
    return wr_en && addr == index;
  endfunction

  // Protected registers only take writes while the key is in place.
  wire wr_clk  = unlocked &&
                 write_hit(bus.wr_en, bus.addr, wdu_pkg::ADDR_CLOCK_CONTROL);
  wire wr_ctl  = unlocked &&
                 write_hit(bus.wr_en, bus.addr, wdu_pkg::ADDR_CONTROL);
  wire wr_protection_key = write_hit(bus.wr_en, bus.addr, wdu_pkg::ADDR_PROTECTION);
  wire restart = wr_ctl && bus.wdata[wdu_pkg::POS_RESTART];
  wire [3:0] run_code = bus.wdata[wdu_pkg::POS_RUN_LO +: 4];

  // The selected source tick; the clock is gated off in debug unless allowed.
  wire src_sel_tick = bus.src_tick[clock_source_select];
  wire gate_open    = !bus.debug_mode || run_in_debug;

  // Log2 of the divisor for the present source and divider code.
  wire [4:0] log2_div =
    (clock_source_select == wdu_pkg::SRC_LOW_XTAL) ? wdu_pkg::LOG2_DIV_LOW_XTAL :
    (clock_source_select == wdu_pkg::SRC_EXT_CLOCK) ? wdu_pkg::LOG2_DIV_EXT :
    wdu_pkg::LOG2_DIV_OSC_BASE + {3'h0, clock_divider_select};

  // Shifting by the full width gives zero, so the slowest ratio masks every bit.
  wire [wdu_pkg::PRESCALE_WIDTH-1:0] div_mask =
    (wdu_pkg::PRESCALE_WIDTH'(1) << log2_div) - wdu_pkg::PRESCALE_WIDTH'(1);

  // A divided tick fires when the prescaler wraps; divide-by-one ticks always.
  wire prescale_step = running && gate_open && src_sel_tick;
  wire counter_tick  = prescale_step && ((prescale & div_mask) == div_mask);
  // A restart in the same cycle wins, so a serviced watchdog never fires late.
  wire overflow      = counter_tick && count == wdu_pkg::COUNTER_MAX && !restart;

  // ----------------------------------------------------------------------
  // Configuration and protection
  // ----------------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      unlocked <= 1'b0;
    else if (wr_protection_key)
      unlocked <= bus.wdata == wdu_pkg::PROTECTION_KEY;
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      run_in_debug         <= 1'b0;
      clock_divider_select <= 2'h0;
      clock_source_select  <= 2'h0;
    end
    else if (wr_clk)
    begin
      run_in_debug         <= bus.wdata[wdu_pkg::POS_RUN_IN_DEBUG];
      clock_divider_select <= bus.wdata[wdu_pkg::POS_DIV_LO +: 2];
      clock_source_select  <= bus.wdata[wdu_pkg::POS_SRC_LO +: 2];
    end
  end

  // The run field is decoded at write time, so any code but stop starts counting.
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      interrupt_or_reset_select <= 1'b0;
      running                   <= 1'b0;
    end
    else if (wr_ctl)
    begin
      interrupt_or_reset_select <= bus.wdata[wdu_pkg::POS_IRQ_OR_RESET];
      running                   <= run_code != wdu_pkg::RUN_STOP_CODE;
    end
  end

  // ----------------------------------------------------------------------
  // Counter, prescaler and overflow outputs
  // ----------------------------------------------------------------------
  // Suspended ticks leave prescaler and counter untouched, so counting resumes in place.
  wire [wdu_pkg::PRESCALE_WIDTH-1:0] next_prescale =
    restart       ? '0 :
    prescale_step ? prescale + wdu_pkg::PRESCALE_WIDTH'(1) :
    prescale;

  wire [wdu_pkg::COUNTER_WIDTH-1:0] next_count =
    restart      ? '0 :
    counter_tick ? count + wdu_pkg::COUNTER_WIDTH'(1) :
    count;

  // The set wins over a clear; restart masks the overflow, so both never meet.
  wire next_overflow_interrupt_status =
    (overflow && interrupt_or_reset_select) ? 1'b1 :
    restart                                 ? 1'b0 :
    overflow_interrupt_status;

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      prescale <= '0;
    else
      prescale <= next_prescale;
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      count <= '0;
    else
      count <= next_count;
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      overflow_interrupt_status <= 1'b0;
    else
      overflow_interrupt_status <= next_overflow_interrupt_status;
  end

  // Registered requests give the far side one clean single-cycle pulse.
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      nmi_req       <= 1'b0;
      sys_reset_req <= 1'b0;
    end
    else
    begin
      nmi_req       <= overflow && interrupt_or_reset_select;
      sys_reset_req <= overflow && !interrupt_or_reset_select;
    end
  end

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  wire [15:0] rd_clk = {7'h00, run_in_debug, 2'h0, clock_divider_select,
                        2'h0, clock_source_select};
  wire [15:0] rd_ctl = {6'h00, interrupt_or_reset_select, overflow_interrupt_status,
                        3'h0, 1'b0,
                        running ? wdu_pkg::RUN_RUNNING_READ : wdu_pkg::RUN_STOP_CODE};

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      rdata <= '0;
    else if (bus.addr == wdu_pkg::ADDR_CLOCK_CONTROL)
      rdata <= rd_clk;
    else if (bus.addr == wdu_pkg::ADDR_CONTROL)
      rdata <= rd_ctl;
    else
      rdata <= {15'h0000, unlocked};
  end

  assign bus.rdata         = rdata;
  assign bus.nmi_req       = nmi_req;
  assign bus.sys_reset_req = sys_reset_req;

endmodule

// ===== wdu_supervisor.sv
`timescale 1ns/1ps

// The processor-side end: runs the start sequence, then services the counter.
module wdu_supervisor
(
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rstn,
  // User side
  input  wire logic        i_start,
  input  wire logic        i_service,
  input  wire logic        i_use_interrupt,
  input  wire logic [1:0]  i_source,
  input  wire logic [1:0]  i_divider,
  input  wire logic        i_run_in_debug,
  input  wire logic [3:0]  i_src_tick,
  input  wire logic        i_debug_mode,
  output logic             o_busy,
  output logic             o_nmi,
  output logic             o_sys_reset,
  // Link to the watchdog
  wdu_if.host              bus
);

  typedef enum {ST_IDLE, ST_UNLOCK, ST_CLOCK, ST_CONTROL, ST_LOCK} wdu_state_t;

  wdu_state_t  state;
  wdu_state_t  next_state;
  logic        starting;
  logic        next_starting;
  logic        wr_en;
  logic [1:0]  addr;
  logic [15:0] wdata;

  // ----------------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_state    = state;
    next_starting = starting;
    wr_en         = 1'b0;
    addr          = wdu_pkg::ADDR_PROTECTION;
    wdata         = 16'h0000;
    case (state)
      ST_IDLE:
      begin
        // Idle reads keep the run and status fields on the read bus for the host.
        addr = wdu_pkg::ADDR_CONTROL;
        if (i_start || i_service)
        begin
          next_starting = i_start;
          next_state    = ST_UNLOCK;
        end
      end
      ST_UNLOCK:
      begin
        wr_en      = 1'b1;
        wdata      = wdu_pkg::PROTECTION_KEY;
        next_state = starting ? ST_CLOCK : ST_CONTROL;
      end
      ST_CLOCK:
      begin
        wr_en      = 1'b1;
        addr       = wdu_pkg::ADDR_CLOCK_CONTROL;
        wdata      = {7'h00, i_run_in_debug, 2'h0, i_divider, 2'h0, i_source};
        next_state = ST_CONTROL;
      end
      ST_CONTROL:
      begin
        // Restart together with run, so a stale count cannot fire at once.
        wr_en      = 1'b1;
        addr       = wdu_pkg::ADDR_CONTROL;
        wdata      = {6'h00, i_use_interrupt, 4'h0, 1'b1, wdu_pkg::RUN_START_CODE};
        next_state = ST_LOCK;
      end
      default:
      begin
        wr_en      = 1'b1;
        wdata      = 16'h0000;
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      state    <= ST_IDLE;
      starting <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      starting <= next_starting;
    end
  end

  assign bus.wr_en      = wr_en;
  assign bus.addr       = addr;
  assign bus.wdata      = wdata;
  assign bus.src_tick   = i_src_tick;
  assign bus.debug_mode = i_debug_mode;
  assign o_busy         = state != ST_IDLE;
  assign o_nmi          = bus.nmi_req;
  assign o_sys_reset    = bus.sys_reset_req;

endmodule

// ===== wdu_asserts.sv
`timescale 1ns/1ps
module wdu_asserts
(
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rstn,
  // Link signals
  input  wire logic        wr_en,
  input  wire logic [1:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic [15:0] rdata,
  input  wire logic [3:0]  src_tick,
  input  wire logic        debug_mode,
  input  wire logic        nmi_req,
  input  wire logic        sys_reset_req
);
  // ----------------------------------------------------------------------
  // Shadow state rebuilt from bus writes
  // ----------------------------------------------------------------------
  // Counts are only modelled for the external source, where one tick is one count.
  logic       unl, run, mode, dbg, st;
  logic [1:0] src;
  logic [9:0] cnt;
  wire        wr_ctl  = wr_en && unl && addr == wdu_pkg::ADDR_CONTROL;
  wire        wr_clk  = wr_en && unl && addr == wdu_pkg::ADDR_CLOCK_CONTROL;
  wire        restart = wr_ctl && wdata[wdu_pkg::POS_RESTART];
  wire        tick    = run && src == wdu_pkg::SRC_EXT_CLOCK && src_tick[3]
                        && (!debug_mode || dbg);
  wire        ovf     = tick && cnt == wdu_pkg::COUNTER_MAX && !restart;
  wire        out     = nmi_req || sys_reset_req;

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      {unl, run, mode, dbg, st, src, cnt} <= '0;
    end
    else
    begin
      if (wr_en && addr == wdu_pkg::ADDR_PROTECTION)
        unl <= wdata == wdu_pkg::PROTECTION_KEY;
      if (wr_clk)
        {dbg, src} <= {wdata[wdu_pkg::POS_RUN_IN_DEBUG], wdata[1:0]};
      if (wr_ctl)
        {mode, run} <= {wdata[wdu_pkg::POS_IRQ_OR_RESET], wdata[3:0] != wdu_pkg::RUN_STOP_CODE};
      st  <= (ovf && mode) ? 1'b1 : (restart ? 1'b0 : st);
      cnt <= restart ? 10'h000 : (tick ? cnt + 10'h001 : cnt);
    end
  end

  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  sequence s_ovf_nmi; ovf && mode; endsequence
  sequence s_ovf_rst; ovf && !mode; endsequence

  AST_OVF_NMI: assert property (s_ovf_nmi |=> nmi_req && !sys_reset_req)
    else $error("overflow in interrupt mode gave wrong output");
  AST_OVF_RST: assert property (s_ovf_rst |=> sys_reset_req && !nmi_req)
    else $error("overflow in reset mode gave wrong output");
  AST_NO_EARLY: assert property (out && $past(src) == 2'h3 |-> $past(ovf))
    else $error("output without a 1024th count");
  AST_ONE_CONSEQ: assert property (!(nmi_req && sys_reset_req))
    else $error("interrupt and reset together");
  AST_DEBUG_HOLD: assert property ((debug_mode && !dbg) [*2] |-> !out)
    else $error("output while suspended in debug");
  AST_RESTART_RD: assert property ($past(addr) == wdu_pkg::ADDR_CONTROL |-> !rdata[4])
    else $error("restart bit read as one");
  AST_RUN_RD: assert property ($past(i_rstn) && $past(addr) == wdu_pkg::ADDR_CONTROL
    |-> rdata[3:0] == ($past(run) ? wdu_pkg::RUN_RUNNING_READ : wdu_pkg::RUN_STOP_CODE))
    else $error("run field read wrong");
  AST_STATUS_RD: assert property ($past(addr) == wdu_pkg::ADDR_CONTROL
    |-> rdata[wdu_pkg::POS_OVF_STATUS] == $past(st))
    else $error("status flag read wrong");
  AST_UNLOCK_RD: assert property ($past(addr) == wdu_pkg::ADDR_PROTECTION
    |-> rdata[0] == $past(unl))
    else $error("protection state read wrong");
endmodule

// ===== wdu_watchdog_unit_tb.sv
`timescale 1ns/1ps
module wdu_watchdog_unit_tb;
  logic       i_ref_clk = 1'b0;
  logic       i_rstn    = 1'b0;
  logic       start = 1'b0, service = 1'b0, use_int = 1'b0, run_dbg = 1'b0, dbg = 1'b0;
  logic [1:0] source    = 2'h3;
  logic [1:0] divider   = 2'h0;
  logic [3:0] tick      = 4'h0;
  logic       busy, nmi, sys_rst;
  int         n_errors  = 0;
  int         n_tests   = 0;
  int         n_nmi, n_rst;

  wdu_if bus_if();
  always #2 i_ref_clk = ~i_ref_clk;

  wdu_watchdog_unit i_wdu_watchdog_unit (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn),
    .bus(bus_if.device));
  wdu_supervisor i_wdu_supervisor (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_start(start),
    .i_service(service), .i_use_interrupt(use_int), .i_source(source), .i_divider(divider),
    .i_run_in_debug(run_dbg), .i_src_tick(tick), .i_debug_mode(dbg), .o_busy(busy),
    .o_nmi(nmi), .o_sys_reset(sys_rst), .bus(bus_if.host));
  wdu_asserts i_wdu_asserts (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .wr_en(bus_if.wr_en),
    .addr(bus_if.addr), .wdata(bus_if.wdata), .rdata(bus_if.rdata),
    .src_tick(bus_if.src_tick), .debug_mode(bus_if.debug_mode), .nmi_req(bus_if.nmi_req),
    .sys_reset_req(bus_if.sys_reset_req));

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string what, input int exp, input int got);
    n_tests++;
    if (exp !== got)
    begin
      n_errors++;
      $display("Error %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic request(input logic is_start);
    int i;
    @(negedge i_ref_clk);
    start <= is_start;
    service <= !is_start;
    @(negedge i_ref_clk);
    start <= 1'b0;
    service <= 1'b0;
    for (i = 0; i < 20 && busy !== 1'b0; i++)
      @(negedge i_ref_clk);
    chk("busy", 0, int'(busy !== 1'b0));
  endtask

  // Ticks are one cycle wide with a gap; the tail lets a late pulse be counted.
  task automatic expect_out(input int n, input int b, input int en, input int er);
    int i;
    n_nmi = 0;
    n_rst = 0;
    for (i = 0; i < 2 * n + 4; i++)
    begin
      @(negedge i_ref_clk);
      tick <= (i < 2 * n && i % 2 == 0) ? 4'(4'h1 << b) : 4'h0;
      // An unknown level counts as a pulse, so it cannot pass for silence.
      n_nmi += int'(nmi !== 1'b0);
      n_rst += int'(sys_rst !== 1'b0);
    end
    chk("nmi pulses", en, n_nmi);
    chk("reset pulses", er, n_rst);
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic test_reset_mode;
    use_int = 1'b0;
    request(1'b1);
    expect_out(1023, 3, 0, 0);
    expect_out(1, 3, 0, 1);
    expect_out(1024, 3, 0, 1);
    expect_out(1000, 3, 0, 0);
    request(1'b0);
    expect_out(1023, 3, 0, 0);
    expect_out(1, 3, 0, 1);
    $display("test reset mode done");
  endtask

  task automatic test_nmi_mode;
    use_int = 1'b1;
    request(1'b1);
    expect_out(1023, 3, 0, 0);
    expect_out(1, 3, 1, 0);
    $display("test nmi mode done");
  endtask

  task automatic test_debug;
    run_dbg = 1'b0;
    request(1'b1);
    expect_out(500, 3, 0, 0);
    dbg = 1'b1;
    expect_out(2000, 3, 0, 0);
    dbg = 1'b0;
    expect_out(523, 3, 0, 0);
    expect_out(1, 3, 1, 0);
    run_dbg = 1'b1;
    request(1'b1);
    dbg = 1'b1;
    expect_out(1023, 3, 0, 0);
    expect_out(1, 3, 1, 0);
    dbg = 1'b0;
    $display("test debug done");
  endtask

  // A slow divided source must ignore the external ticks and not overflow early.
  task automatic test_source;
    source = 2'h0;
    divider = 2'h3;
    request(1'b1);
    expect_out(1100, 3, 0, 0);
    expect_out(1100, 0, 0, 0);
    $display("test source done");
  endtask

  task automatic complete_run;
    $display("Comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    repeat (20) @(negedge i_ref_clk);
    i_rstn = 1'b1;
    test_reset_mode;
    test_nmi_mode;
    test_debug;
    test_source;
    complete_run;
  end

  initial
  begin
    #200000;
    n_errors++;
    $display("Error watchdog expired before the tests ended");
    complete_run;
  end
endmodule
